/* rtl/port_a_io_window.sv */
// port A I/O, register window decode and track buffer
`timescale 1ns/10ps
`default_nettype none
module port_a_io_window
    import port_window_pkg::*;
#(
    parameter bit HAS_POWER_MGMT = 1'b1
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic srst_i,
    // host bus and configuration
    input wire host_ctl_type host_i,
    input wire config_type cfg_i,
    input wire logic [LOW_DECODE_W-1:0] low_decode_lines_i,
    input wire logic track_inbound_select_i,
    input wire logic track_addr_out_select_i,
    input wire logic track_data_out_select_i,
    output logic register_window_select_o,
    // multiplexed low address/data bus
    input wire logic [7:0] low_addr_data_bus_i,
    output logic [7:0] low_addr_data_bus_o,
    output logic [7:0] low_addr_data_bus_oe_o,
    // high data lane for 16-bit buses
    input wire logic [7:0] high_data_i,
    output logic [7:0] high_data_o,
    output logic [7:0] high_data_oe_o,
    // first port pins
    input wire logic [7:0] first_port_pins_i,
    output logic [7:0] first_port_pins_o,
    output logic [7:0] first_port_pins_oe_o,
    // second port and misc register outputs
    input wire logic [7:0] port_b_pins_i,
    output logic [7:0] port_b_direction_o,
    output logic [7:0] port_b_output_latch_o,
    output logic [7:0] power_management_o,
    output logic [PAGE_W-1:0] memory_page_o
);
    logic [7:0] a_pin_reg;
    logic [7:0] b_pin_reg;
    logic [7:0] a_dir_reg;
    logic [7:0] b_dir_reg;
    logic [7:0] a_out_reg;
    logic [7:0] b_out_reg;
    logic [7:0] power_reg;
    logic [PAGE_W-1:0] page_reg;
    logic [7:0] addr_lat_reg;
    logic [7:0] rd_hi_reg;
    logic [7:0] bus_o_reg;
    logic [7:0] bus_oe_reg;
    logic [7:0] hi_oe_reg;
    logic [7:0] pin_o_reg;
    logic [7:0] pin_oe_reg;
    logic [7:0] bus_o_next;
    logic [7:0] bus_oe_next;
    logic [7:0] pin_o_next;
    logic [7:0] pin_oe_next;
    logic [7:0] io_val;
    logic [7:0] io_drive;
    logic [OFS_W-1:0] offset;
    logic [OFS_W-1:0] lo_ofs;
    logic [OFS_W-1:0] hi_ofs;
    logic [7:0] wdata_lo;
    logic win_hit;
    logic wr_act;
    logic rd_act;
    logic lane_lo;
    logic lane_hi;
    logic rd_hit;
    logic wr_hit;
    logic track_addr_out;
    logic track_data_out;
    logic track_in;
    port_mode_type mode;

    // window decode on upper lines plus optional low lines
    assign win_hit = (host_i.addr_hi[15:WIN_LSB] == cfg_i.window_base) &&
        (((low_decode_lines_i ^ cfg_i.low_decode_match) & cfg_i.low_decode_mask) == '0);
    assign register_window_select_o = win_hit;

    // strobe qualifiers per strobe style
    assign wr_act = cfg_i.strobe_style_select ?
        (host_i.bus_enable_phase & ~host_i.read_not_write) : ~host_i.write_strobe_n;
    assign rd_act = cfg_i.strobe_style_select ?
        (host_i.bus_enable_phase & host_i.read_not_write) : ~host_i.read_strobe_n;
    assign rd_hit = win_hit & rd_act;
    assign wr_hit = win_hit & wr_act;

    // offset source and byte lanes
    assign offset = cfg_i.mux_mode ? addr_lat_reg[OFS_W-1:0] : host_i.addr_lo[OFS_W-1:0];
    assign lane_lo = ~cfg_i.bus_16bit | ~offset[0];
    assign lane_hi = cfg_i.bus_16bit & ~host_i.high_byte_enable_n;
    assign lo_ofs = cfg_i.bus_16bit ? {offset[OFS_W-1:1], 1'b0} : offset;
    assign hi_ofs = {offset[OFS_W-1:1], 1'b1};
    assign wdata_lo = cfg_i.mux_mode ? low_addr_data_bus_i : first_port_pins_i;

    // byte write strobe for one register offset
    function automatic logic byte_wr(input logic [OFS_W-1:0] ofs);
        byte_wr = wr_hit && ((lane_lo && lo_ofs == ofs) || (lane_hi && hi_ofs == ofs));
    endfunction

    // lane data for one register offset
    function automatic logic [7:0] byte_wdata(input logic [OFS_W-1:0] ofs);
        byte_wdata = (cfg_i.bus_16bit && ofs[0]) ? high_data_i : wdata_lo;
    endfunction

    // read mux, unmapped offsets read zero
    function automatic logic [7:0] read_byte(input logic [OFS_W-1:0] ofs);
        case (ofs)
            OFS_A_PIN: read_byte = a_pin_reg;
            OFS_B_PIN: read_byte = b_pin_reg;
            OFS_A_DIR: read_byte = a_dir_reg;
            OFS_B_DIR: read_byte = b_dir_reg;
            OFS_A_OUT: read_byte = a_out_reg;
            OFS_B_OUT: read_byte = b_out_reg;
            OFS_POWER: read_byte = HAS_POWER_MGMT ? power_reg : UNMAPPED_READ;
            OFS_PAGE: read_byte = {{(8-PAGE_W){1'b0}}, page_reg};
            default: read_byte = UNMAPPED_READ;
        endcase
    endfunction

    // mode selection; data-bus mode whenever mux_mode is clear, track or I/O mode only with mux_mode set
    always_comb begin
        if (!cfg_i.mux_mode) begin
            mode = MODE_DATABUS;
        end else if (cfg_i.track_mode) begin
            mode = MODE_TRACK;
        end else begin
            mode = MODE_IO;
        end
    end

    // pin sampling, every cycle
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            a_pin_reg <= 8'h00;
            b_pin_reg <= 8'h00;
        end else begin
            a_pin_reg <= first_port_pins_i;
            b_pin_reg <= port_b_pins_i;
        end
    end

    // low address latch, follows bus while strobe high, holds after its fall
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            addr_lat_reg <= ADDR_RESET;
        end else if (host_i.addr_latch_strobe) begin
            addr_lat_reg <= low_addr_data_bus_i;
        end
    end

    // first port registers
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            a_dir_reg <= DIR_RESET;
            a_out_reg <= LATCH_RESET;
        end else begin
            if (byte_wr(OFS_A_DIR)) begin
                a_dir_reg <= byte_wdata(OFS_A_DIR);
            end
            if (byte_wr(OFS_A_OUT)) begin
                a_out_reg <= byte_wdata(OFS_A_OUT);
            end
        end
    end

    // second port registers
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            b_dir_reg <= DIR_RESET;
            b_out_reg <= LATCH_RESET;
        end else begin
            if (byte_wr(OFS_B_DIR)) begin
                b_dir_reg <= byte_wdata(OFS_B_DIR);
            end
            if (byte_wr(OFS_B_OUT)) begin
                b_out_reg <= byte_wdata(OFS_B_OUT);
            end
        end
    end

    // power management and page registers
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            power_reg <= POWER_RESET;
            page_reg <= PAGE_RESET;
        end else begin
            if (HAS_POWER_MGMT && byte_wr(OFS_POWER)) begin
                power_reg <= byte_wdata(OFS_POWER);
            end
            if (byte_wr(OFS_PAGE)) begin
                page_reg <= PAGE_W'(byte_wdata(OFS_PAGE));
            end
        end
    end

    // track mode direction terms
    assign track_addr_out = host_i.addr_latch_strobe & track_addr_out_select_i;
    assign track_data_out = track_data_out_select_i & wr_act;
    assign track_in = track_inbound_select_i & rd_act;

    // per-pin I/O mode value and drive
    genvar n;
    generate
        for (n = 0; n < 8; n = n + 1) begin : g_pin
            assign io_val[n] = cfg_i.latched_addr_enable[n] ?
                addr_lat_reg[n] : a_out_reg[n];
            assign io_drive[n] = cfg_i.latched_addr_enable[n] | a_dir_reg[n];
        end
    endgenerate

    // next pin drive per mode
    always_comb begin
        pin_o_next = 8'h00;
        pin_oe_next = 8'h00;
        case (mode)
            MODE_IO: begin
                pin_o_next = io_val & ~cfg_i.output_drive_type;
                pin_oe_next = io_drive & (~cfg_i.output_drive_type | ~io_val);
            end
            MODE_TRACK: begin
                if (track_addr_out || track_data_out) begin
                    pin_o_next = low_addr_data_bus_i;
                    pin_oe_next = 8'hff;
                end
            end
            MODE_DATABUS: begin
                pin_o_next = read_byte(lo_ofs);
                pin_oe_next = {8{rd_hit & lane_lo}};
            end
            default: begin
                pin_o_next = 8'h00;
                pin_oe_next = 8'h00;
            end
        endcase
    end

    // next low bus drive: window reads or track inbound
    always_comb begin
        bus_o_next = 8'h00;
        bus_oe_next = 8'h00;
        if (mode == MODE_TRACK && track_in) begin
            bus_o_next = first_port_pins_i;
            bus_oe_next = 8'hff;
        end else if (cfg_i.mux_mode && rd_hit && lane_lo) begin
            bus_o_next = read_byte(lo_ofs);
            bus_oe_next = 8'hff;
        end
    end

    // registered outputs
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            pin_o_reg <= 8'h00;
            pin_oe_reg <= 8'h00;
            bus_o_reg <= 8'h00;
            bus_oe_reg <= 8'h00;
            rd_hi_reg <= 8'h00;
            hi_oe_reg <= 8'h00;
        end else begin
            pin_o_reg <= pin_o_next;
            pin_oe_reg <= pin_oe_next;
            bus_o_reg <= bus_o_next;
            bus_oe_reg <= bus_oe_next;
            rd_hi_reg <= read_byte(hi_ofs);
            hi_oe_reg <= {8{rd_hit & lane_hi}};
        end
    end

    assign first_port_pins_o = pin_o_reg;
    assign first_port_pins_oe_o = pin_oe_reg;
    assign low_addr_data_bus_o = bus_o_reg;
    assign low_addr_data_bus_oe_o = bus_oe_reg;
    assign high_data_o = rd_hi_reg;
    assign high_data_oe_o = hi_oe_reg;
    assign port_b_direction_o = b_dir_reg;
    assign port_b_output_latch_o = b_out_reg;
    assign power_management_o = power_reg;
    assign memory_page_o = page_reg;

    // checks
    sequence s_ale_trailing;
        host_i.addr_latch_strobe ##1 !host_i.addr_latch_strobe;
    endsequence

    sequence s_a_dir_write;
        wr_hit && !cfg_i.bus_16bit && offset == OFS_A_DIR;
    endsequence

    AST_RESET_CLEARS: assert property (@(posedge core_clk_i)
        $fell(srst_i) |-> a_dir_reg == DIR_RESET && a_out_reg == LATCH_RESET)
        else $error("port registers not cleared by reset");

    AST_A_DIR_WRITE: assert property (@(posedge core_clk_i) disable iff (srst_i)
        s_a_dir_write |=> a_dir_reg == $past(wdata_lo))
        else $error("direction write not stored");

    AST_NO_STRAY_WRITE: assert property (@(posedge core_clk_i) disable iff (srst_i)
        !wr_hit |=> $stable(a_dir_reg) && $stable(a_out_reg) && $stable(b_dir_reg))
        else $error("register changed without a window write");

    AST_HIGH_LANE_WRITE: assert property (@(posedge core_clk_i) disable iff (srst_i)
        wr_hit && cfg_i.bus_16bit && !host_i.high_byte_enable_n && offset == OFS_A_DIR
        |=> b_dir_reg == $past(high_data_i))
        else $error("high lane word write missed");

    AST_PIN_READ: assert property (@(posedge core_clk_i) disable iff (srst_i)
        mode == MODE_IO && rd_hit && lane_lo && lo_ofs == OFS_A_PIN
        |=> low_addr_data_bus_o == $past(first_port_pins_i, 2))
        else $error("pin level read wrong");

    // push-pull bits follow the flops, open-drain bits only pull low
    AST_IO_PUSH_PULL: assert property (@(posedge core_clk_i) disable iff (srst_i)
        mode == MODE_IO && cfg_i.latched_addr_enable == 8'h00
        |=> ((pin_oe_reg ^ $past(a_dir_reg)) & ~cfg_i.output_drive_type) == 8'h00
            && ((pin_o_reg ^ $past(a_out_reg)) & ~cfg_i.output_drive_type) == 8'h00)
        else $error("push-pull pin drive wrong");

    AST_IO_OPEN_DRAIN: assert property (@(posedge core_clk_i) disable iff (srst_i)
        mode == MODE_IO && cfg_i.latched_addr_enable == 8'h00
        |=> (pin_o_reg & cfg_i.output_drive_type) == 8'h00
            && ((pin_oe_reg ^ $past(a_dir_reg & ~a_out_reg)) & cfg_i.output_drive_type) == 8'h00)
        else $error("open-drain pin drive wrong");

    AST_ADDR_LATCH: assert property (@(posedge core_clk_i) disable iff (srst_i)
        s_ale_trailing |-> addr_lat_reg == $past(low_addr_data_bus_i) ##1 $stable(addr_lat_reg)
            || host_i.addr_latch_strobe)
        else $error("address not captured at strobe fall");

    AST_TRACK_ADDR_OUT: assert property (@(posedge core_clk_i) disable iff (srst_i)
        mode == MODE_TRACK && track_addr_out
        |=> pin_oe_reg == 8'hff && pin_o_reg == $past(low_addr_data_bus_i))
        else $error("track address not driven to pins");

    AST_TRACK_IDLE: assert property (@(posedge core_clk_i) disable iff (srst_i)
        mode == MODE_TRACK && !track_addr_out && !track_data_out |=> pin_oe_reg == 8'h00)
        else $error("track pins driven while idle");

    AST_TRACK_INBOUND: assert property (@(posedge core_clk_i) disable iff (srst_i)
        mode == MODE_TRACK && track_in
        |=> low_addr_data_bus_oe_o == 8'hff && low_addr_data_bus_o == $past(first_port_pins_i))
        else $error("track inbound data not on bus");
endmodule
`default_nettype wire

/* rtl/port_window_pkg.sv */
// constants, carrier structs and mode encodings for the port A register window
package port_window_pkg;
    localparam int OFS_W = 5;
    localparam logic [4:0] OFS_A_PIN = 5'h02;
    localparam logic [4:0] OFS_B_PIN = 5'h03;
    localparam logic [4:0] OFS_A_DIR = 5'h04;
    localparam logic [4:0] OFS_B_DIR = 5'h05;
    localparam logic [4:0] OFS_A_OUT = 5'h06;
    localparam logic [4:0] OFS_B_OUT = 5'h07;
    localparam logic [4:0] OFS_POWER = 5'h10;
    localparam logic [4:0] OFS_PAGE = 5'h18;
    localparam int WIN_LSB = 11;
    localparam int PAGE_W = 4;
    localparam int LOW_DECODE_W = 3;
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [7:0] POWER_RESET = 8'h00;
    localparam logic [3:0] PAGE_RESET = 4'h0;
    localparam logic [7:0] ADDR_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // port A operating modes
    typedef enum logic [2:0] {
        MODE_IO = 3'b001,
        MODE_TRACK = 3'b010,
        MODE_DATABUS = 3'b100
    } port_mode_type;

    // host bus strobes and address
    typedef struct packed {
        logic [15:8] addr_hi;
        logic [7:0] addr_lo;
        logic addr_latch_strobe;
        logic read_strobe_n;
        logic write_strobe_n;
        logic read_not_write;
        logic bus_enable_phase;
        logic high_byte_enable_n;
    } host_ctl_type;

    // configuration fixed before run time
    typedef struct packed {
        logic mux_mode;
        logic bus_16bit;
        logic strobe_style_select;
        logic track_mode;
        logic [7:0] latched_addr_enable;
        logic [7:0] output_drive_type;
        logic [15:WIN_LSB] window_base;
        logic [LOW_DECODE_W-1:0] low_decode_mask;
        logic [LOW_DECODE_W-1:0] low_decode_match;
    } config_type;
endpackage

/* testbench/host_bus_model.sv */
// host microcontroller model on the multiplexed bus of the port window
`timescale 1ns/10ps
`default_nettype none
module host_bus_model
    import port_window_pkg::*;
(
    // clock
    input wire logic core_clk_i,
    // bus towards the window
    output var host_ctl_type host_o,
    output logic [7:0] ad_o,
    input wire logic [7:0] ad_i,
    input wire logic [7:0] hi_i
);
    host_ctl_type ctl;
    logic [7:0] ad;

    assign host_o = ctl;
    assign ad_o = ad;

    // idle bus: no strobe, high byte not wanted
    initial begin
        ctl = '0;
        ctl.read_strobe_n = 1'b1;
        ctl.write_strobe_n = 1'b1;
        ctl.read_not_write = 1'b1;
        ctl.high_byte_enable_n = 1'b1;
        ad = 8'h00;
    end

    // both strobe styles from one setting so either qualifier works
    task automatic set(input logic ale, input logic rd_n, input logic wr_n, input logic [7:0] d);
        ctl.addr_latch_strobe = ale;
        ctl.read_strobe_n = rd_n;
        ctl.write_strobe_n = wr_n;
        ctl.read_not_write = wr_n;
        ctl.bus_enable_phase = !(rd_n && wr_n);
        ad = d;
    endtask

    // change the bus just after a falling edge
    task automatic step(input logic ale, input logic rd_n, input logic wr_n, input logic [7:0] d);
        @(negedge core_clk_i);
        set(ale, rd_n, wr_n, d);
    endtask

    // enable-phase strobes only, plain read and write strobes left idle
    task automatic step_e(input logic e, input logic rnw, input logic [7:0] d);
        @(negedge core_clk_i);
        ctl.addr_latch_strobe = 1'b0;
        ctl.read_strobe_n = 1'b1;
        ctl.write_strobe_n = 1'b1;
        ctl.read_not_write = rnw;
        ctl.bus_enable_phase = e;
        ad = d;
    endtask

    // address phase, data phase, then release with the inverse on the bus
    task automatic write(input logic [15:0] a, input logic [7:0] d);
        step(1'b1, 1'b1, 1'b1, a[7:0]);
        ctl.addr_hi = a[15:8];
        ctl.addr_lo = a[7:0];
        step(1'b0, 1'b1, 1'b0, d);
        step(1'b0, 1'b1, 1'b1, ~d);
    endtask

    // read strobe held over two rising edges, data taken before release
    task automatic read(input logic [15:0] a, output logic [15:0] q);
        step(1'b1, 1'b1, 1'b1, a[7:0]);
        ctl.addr_hi = a[15:8];
        ctl.addr_lo = a[7:0];
        step(1'b0, 1'b0, 1'b1, ~a[7:0]);
        @(negedge core_clk_i);
        @(negedge core_clk_i);
        q = {hi_i, ad_i};
        set(1'b0, 1'b1, 1'b1, a[7:0]);
    endtask
endmodule
`default_nettype wire

/* testbench/tb.sv */
// testbench for the port A register window, pins and track buffer
`timescale 1ns/10ps
`default_nettype none
module tb;
    import port_window_pkg::*;
    localparam logic [15:0] BASE = 16'h6800;
    logic core_clk_i;
    logic srst_i;
    config_type cfg;
    host_ctl_type host;
    logic [7:0] ad_host, ad_dut, ad_oe, hi_dut, hi_oe, pin_o, pin_oe, pin_ext;
    logic [7:0] b_dir, b_out, pwr, hi_host;
    logic [3:0] page;
    logic [2:0] low_lines;
    logic sel_in, sel_aout, sel_dout, win_hit;
    logic [15:0] q;
    int fail_count;
    int tests_run;
    wire logic [7:0] pins;
    wire logic [7:0] bus;

    // driven pin bits follow the port, others the outside source
    assign pins = (pin_oe & pin_o) | (~pin_oe & pin_ext);
    assign bus = (ad_oe & ad_dut) | (~ad_oe & ad_host);

    port_a_io_window dut (
        .core_clk_i(core_clk_i), .srst_i(srst_i), .host_i(host), .cfg_i(cfg),
        .low_decode_lines_i(low_lines), .track_inbound_select_i(sel_in),
        .track_addr_out_select_i(sel_aout), .track_data_out_select_i(sel_dout),
        .register_window_select_o(win_hit), .low_addr_data_bus_i(bus),
        .low_addr_data_bus_o(ad_dut), .low_addr_data_bus_oe_o(ad_oe),
        .high_data_i(hi_host), .high_data_o(hi_dut), .high_data_oe_o(hi_oe),
        .first_port_pins_i(pins), .first_port_pins_o(pin_o),
        .first_port_pins_oe_o(pin_oe), .port_b_pins_i(~pin_ext),
        .port_b_direction_o(b_dir), .port_b_output_latch_o(b_out),
        .power_management_o(pwr), .memory_page_o(page)
    );

    host_bus_model hp (
        .core_clk_i(core_clk_i), .host_o(host), .ad_o(ad_host), .ad_i(ad_dut), .hi_i(hi_dut)
    );

    // compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // read one byte at a window offset and compare the low lane
    task automatic rd(input logic [7:0] ofs, input logic [7:0] exp);
        hp.read(BASE + {8'h00, ofs}, q);
        check(q[7:0], exp);
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // 100 MHz clock
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end

    // watchdog at 2000 cycles, well beyond the 135 or so cycles the tests need
    initial begin
        #20000;
        fail_count++;
        conclude();
    end

    initial begin
        fail_count = 0;
        tests_run = 0;
        srst_i = 1'b1;
        cfg = '0;
        cfg.mux_mode = 1'b1;
        cfg.window_base = BASE[15:11];
        cfg.output_drive_type = 8'h01;
        low_lines = 3'h0;
        sel_in = 1'b0;
        sel_aout = 1'b0;
        sel_dout = 1'b0;
        pin_ext = 8'h5a;
        hi_host = 8'h00;
        repeat (2) @(negedge core_clk_i);
        srst_i = 1'b0;
        // reset state
        check(pin_oe, 8'h00);
        rd(8'h04, 8'h00);
        rd(8'h06, 8'h00);
        rd(8'h18, 8'h00);
        $display("reset test done");
        // port A direction and latch, open-drain bit 0 high so floating
        hp.write(BASE + 16'h4, 8'ha5);
        hp.write(BASE + 16'h6, 8'h3d);
        hp.write(BASE + 16'h2, 8'hff);
        check(pin_oe, 8'ha4);
        check(pin_o & pin_oe, 8'h24);
        rd(8'h02, 8'h7e);
        rd(8'h04, 8'ha5);
        rd(8'h06, 8'h3d);
        $display("port A test done");
        // second port, power and page registers, unmapped place
        hp.write(BASE + 16'h5, 8'h81);
        hp.write(BASE + 16'h7, 8'h42);
        hp.write(BASE + 16'h10, 8'h99);
        hp.write(BASE + 16'h18, 8'hf6);
        hp.write(BASE + 16'h3, 8'h00);
        rd(8'h03, 8'ha5);
        rd(8'h05, 8'h81);
        rd(8'h07, 8'h42);
        rd(8'h10, 8'h99);
        rd(8'h18, 8'h06);
        rd(8'h08, 8'h00);
        check(b_dir, 8'h81);
        check(b_out, 8'h42);
        check(pwr, 8'h99);
        check({4'h0, page}, 8'h06);
        $display("register map test done");
        // aliasing, misses and the extra decode line
        hp.read(BASE + 16'h0704, q);
        check(q[7:0], 8'ha5);
        hp.write(16'h7004, 8'h00);
        cfg.low_decode_mask = 3'h1;
        cfg.low_decode_match = 3'h1;
        hp.write(BASE + 16'h4, 8'h00);
        low_lines = 3'h1;
        rd(8'h04, 8'ha5);
        check({7'h00, win_hit}, 8'h01);
        low_lines = 3'h0;
        #1;
        check({7'h00, win_hit}, 8'h00);
        $display("decode test done");
        // latched low address on the lower four pins
        cfg.latched_addr_enable = 8'h0f;
        hp.read(BASE + 16'h0396, q);
        check(pin_oe, 8'haf);
        check(pin_o & pin_oe, 8'h26);
        $display("latched address test done");
        // track mode: address out, data out in both styles, inbound, float
        cfg.latched_addr_enable = 8'h00;
        cfg.track_mode = 1'b1;
        sel_aout = 1'b1;
        hp.step(1'b1, 1'b1, 1'b1, 8'hc3);
        @(negedge core_clk_i);
        check(pin_oe, 8'hff);
        check(pin_o, 8'hc3);
        hp.step(1'b0, 1'b1, 1'b1, 8'h3c);
        sel_aout = 1'b0;
        @(negedge core_clk_i);
        check(pin_oe, 8'h00);
        sel_dout = 1'b1;
        hp.step(1'b0, 1'b1, 1'b0, 8'h5e);
        @(negedge core_clk_i);
        check(pin_oe, 8'hff);
        check(pin_o, 8'h5e);
        cfg.strobe_style_select = 1'b1;
        hp.step_e(1'b1, 1'b0, 8'h71);
        @(negedge core_clk_i);
        check(pin_o, 8'h71);
        hp.step_e(1'b1, 1'b1, 8'h8e);
        @(negedge core_clk_i);
        check(pin_oe, 8'h00);
        sel_dout = 1'b0;
        sel_in = 1'b1;
        hp.step(1'b0, 1'b0, 1'b1, 8'h00);
        @(negedge core_clk_i);
        check(ad_oe, 8'hff);
        check(ad_dut, 8'h5a);
        hp.step(1'b0, 1'b1, 1'b1, 8'hff);
        sel_in = 1'b0;
        $display("track test done");
        // 16-bit bus word reads and writes with the high byte enabled
        cfg.track_mode = 1'b0;
        cfg.strobe_style_select = 1'b0;
        cfg.bus_16bit = 1'b1;
        low_lines = 3'h1;
        hp.ctl.high_byte_enable_n = 1'b0;
        hp.read(BASE + 16'h4, q);
        check(q[7:0], 8'ha5);
        check(q[15:8], 8'h81);
        hi_host = 8'h3c;
        hp.write(BASE + 16'h4, 8'h5a);
        hp.read(BASE + 16'h4, q);
        check(q[7:0], 8'h5a);
        check(q[15:8], 8'h3c);
        hi_host = 8'h77;
        hp.write(BASE + 16'h5, 8'h00);
        check(b_dir, 8'h77);
        hp.read(BASE + 16'h4, q);
        check(q[7:0], 8'h5a);
        check(q[15:8], 8'h77);
        hp.ctl.high_byte_enable_n = 1'b1;
        $display("wide bus test done");
        // second reset in mid-run
        srst_i = 1'b1;
        @(negedge core_clk_i);
        srst_i = 1'b0;
        rd(8'h06, 8'h00);
        $display("mid-run reset test done");
        // non-multiplexed bus: port A pins carry the data byte
        cfg.mux_mode = 1'b0;
        cfg.bus_16bit = 1'b0;
        pin_ext = 8'h3c;
        hp.write(BASE + 16'h6, 8'h00);
        hp.read(BASE + 16'h6, q);
        check(pin_oe, 8'hff);
        check(pin_o, 8'h3c);
        $display("data byte test done");
        conclude();
    end
endmodule
`default_nettype wire
